// ==== rtl/pbc_fb_sel.sv ====
// feedback level selector: feedback pin level for the motor state
`timescale 1ns/1ps
module pbc_fb_sel (
    input  wire logic                    i_clk,
    input  wire logic                    i_reset,
    input  wire pbc_pkg::pbc_motor_e     i_state,
    input  wire logic [1:0]              i_stop_sel,
    input  wire logic [1:0]              i_fault_sel,
    input  wire logic                    i_general_level,
    input  wire logic                    i_run_level,
    output logic                         o_level
);
    import pbc_pkg::*;

    logic held_reg;
    logic held_next;
    logic lvl_next;

    // keep last run level for a fault to show
    always_comb begin
        held_next = (i_state == PBC_RUN) ? i_run_level : held_reg;
        lvl_next  = i_general_level;
        case (i_state)
            PBC_STOP: begin
                case (i_stop_sel)
                    PBC_SEL_0: lvl_next = i_general_level;   // RL1
                    PBC_SEL_2: lvl_next = 1'b0;              // RL2
                    default:   lvl_next = 1'b1;              // RL2
                endcase
            end
            PBC_FAULT: begin
                case (i_fault_sel)
                    PBC_SEL_0: lvl_next = held_reg;          // RL3
                    PBC_SEL_1: lvl_next = 1'b1;              // RL4
                    PBC_SEL_2: lvl_next = 1'b0;              // RL4
                    default:   lvl_next = i_general_level;   // RL4
                endcase
            end
            default: lvl_next = i_run_level;
        endcase
    end

    // state change shows at the next edge
    always_ff @(posedge i_clk) begin
        held_reg <= i_reset ? 1'b0 : held_next;
        o_level  <= i_reset ? 1'b0 : lvl_next; // RL8
    end

endmodule : pbc_fb_sel

// ==== rtl/pbc_pkg.sv ====
// package: register map and encodings of the pin behaviour config block
package pbc_pkg;

    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [7:0] PBC_OFS_PIN_CFG    = 8'h00;
    localparam logic [7:0] PBC_OFS_STATUS     = 8'h04;
    localparam logic [7:0] PBC_OFS_ALIGN_ANG  = 8'h08;

    // ****************************************************************
    // pin config field positions
    // ****************************************************************
    localparam int PBC_STOP_SEL_LSB  = 9;
    localparam int PBC_FAULT_SEL_LSB = 7;
    localparam int PBC_ALARM_EN_BIT  = 6;
    localparam int PBC_BRAKE_STY_BIT = 5;
    localparam int PBC_ANG_SRC_BIT   = 4;
    localparam int PBC_SEL_W         = 2;

    // status field positions
    localparam int PBC_ST_FB_BIT     = 0;
    localparam int PBC_ST_STATE_LSB  = 1;
    localparam int PBC_ST_ALARM_BIT  = 3;
    localparam int PBC_ST_LSBRK_BIT  = 4;
    localparam int PBC_ST_ALBRK_BIT  = 5;

    // ****************************************************************
    // reset values and bus answers
    // ****************************************************************
    localparam logic [31:0] PBC_PIN_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] PBC_ALIGN_RST   = 32'h0000_0000;
    localparam logic [1:0]  PBC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  PBC_RESP_SLVERR = 2'h2;

    // feedback level selector encodings
    localparam logic [1:0] PBC_SEL_0 = 2'h0;
    localparam logic [1:0] PBC_SEL_1 = 2'h1;
    localparam logic [1:0] PBC_SEL_2 = 2'h2;
    localparam logic [1:0] PBC_SEL_3 = 2'h3;

    // motor state
    typedef enum logic [1:0] {
        PBC_RUN   = 2'b00,
        PBC_STOP  = 2'b01,
        PBC_FAULT = 2'b10
    } pbc_motor_e;

endpackage : pbc_pkg

// ==== rtl/pbc_regs.sv ====
// register store: byte-lane writes, registered read data
`timescale 1ns/1ps
module pbc_regs #(
    parameter int N_WORDS = 2
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_reset,
    input  wire logic                       i_wr_en,
    input  wire logic [$clog2(N_WORDS)-1:0] i_wr_idx,
    input  wire logic [31:0]                i_wr_data,
    input  wire logic [3:0]                 i_wr_strb,
    input  wire logic [$clog2(N_WORDS)-1:0] i_rd_idx,
    output logic      [31:0]                o_rd_data,
    output logic      [N_WORDS*32-1:0]      o_words
);
    import pbc_pkg::*;

    initial begin
        if (N_WORDS < 2) $error("pbc_regs needs at least two words");
    end

    logic [31:0] mem_reg  [N_WORDS];
    logic [31:0] mem_next [N_WORDS];
    logic [31:0] rd_next;

    // byte-lane merge; reads see the stored word
    always_comb begin
        for (int w = 0; w < N_WORDS; w++) begin
            mem_next[w] = mem_reg[w];
            if (i_wr_en && (i_wr_idx == w[$clog2(N_WORDS)-1:0])) begin
                for (int b = 0; b < 4; b++) begin
                    if (i_wr_strb[b]) mem_next[w][b*8 +: 8] = i_wr_data[b*8 +: 8];
                end
            end
        end
        rd_next = mem_reg[i_rd_idx];
    end

    always_ff @(posedge i_clk) begin
        for (int w = 0; w < N_WORDS; w++) begin
            mem_reg[w] <= i_reset ? PBC_PIN_CFG_RST : mem_next[w];
        end
        o_rd_data <= i_reset ? 32'h0000_0000 : rd_next;
    end

    // flat view for field decode
    always_comb begin
        for (int w = 0; w < N_WORDS; w++) o_words[w*32 +: 32] = mem_reg[w];
    end

endmodule : pbc_regs

// ==== rtl/pbc_top.sv ====
// top of the pin behaviour config block: axi4-lite slave, field decode, pin control
//
// Summary of operation
// RL1 - stopped, stop selector zero: feedback follows general setting
// RL2 - stopped: selector one or three drives feedback high, two low
// RL3 - fault, fault selector zero: keep last level from driven motor
// RL4 - fault: selector one high, two low, three follows general setting
// RL5 - alarm pin active only while alarm enable is one
// RL6 - brake request: low-side brake on style zero, align brake on one
// RL7 - align brake angle: last commutation on source zero, configured on one
// RL8 - feedback reevaluated at once on motor state change
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module pbc_top #(
    parameter int ANGLE_W = 16
) (
    input  wire logic                i_clk,
    input  wire logic                i_reset,
    // axi4-lite slave
    input  wire logic [7:0]          i_s_axi_awaddr,
    input  wire logic                i_s_axi_awvalid,
    output logic                     o_s_axi_awready,
    input  wire logic [31:0]         i_s_axi_wdata,
    input  wire logic [3:0]          i_s_axi_wstrb,
    input  wire logic                i_s_axi_wvalid,
    output logic                     o_s_axi_wready,
    output logic [1:0]               o_s_axi_bresp,
    output logic                     o_s_axi_bvalid,
    input  wire logic                i_s_axi_bready,
    input  wire logic [7:0]          i_s_axi_araddr,
    input  wire logic                i_s_axi_arvalid,
    output logic                     o_s_axi_arready,
    output logic [31:0]              o_s_axi_rdata,
    output logic [1:0]               o_s_axi_rresp,
    output logic                     o_s_axi_rvalid,
    input  wire logic                i_s_axi_rready,
    // motor core side
    input  wire pbc_pkg::pbc_motor_e i_motor_state,
    input  wire logic                i_general_feedback_setting,
    input  wire logic                i_run_feedback_level,
    input  wire logic                i_alarm_event,
    input  wire logic                i_brake_req,
    input  wire logic [ANGLE_W-1:0]  i_last_comm_angle,
    // pin and brake control
    output logic                     o_speed_feedback_out,
    output logic                     o_alarm_pin,
    output logic                     o_low_side_brake,
    output logic                     o_align_brake,
    output logic [ANGLE_W-1:0]       o_brake_angle
);
    import pbc_pkg::*;

    localparam int N_WORDS = 2;
    localparam int IDX_W   = 1;

    initial begin
        if (ANGLE_W < 1 || ANGLE_W > 32) $error("pbc_top: ANGLE_W must be 1..32");
    end

    // ****************************************************************
    // address decode
    // ****************************************************************
    // words: 0 pin config, 1 align angle; status is live
    function automatic logic [2:0] dec_addr(input logic [7:0] a);
        if (a == PBC_OFS_PIN_CFG)        dec_addr = 3'h1;
        else if (a == PBC_OFS_ALIGN_ANG) dec_addr = 3'h2;
        else if (a == PBC_OFS_STATUS)    dec_addr = 3'h4;
        else                             dec_addr = 3'h0;
    endfunction : dec_addr

    // ****************************************************************
    // write channel: address and data taken in either order
    // ****************************************************************
    logic        aw_hold_reg, aw_hold_next;
    logic [7:0]  aw_addr_reg, aw_addr_next;

    logic        w_hold_reg,  w_hold_next;
    logic [31:0] w_data_reg,  w_data_next;
    logic [3:0]  w_strb_reg,  w_strb_next;

    logic        bvalid_reg,  bvalid_next;
    logic [1:0]  bresp_reg,   bresp_next;

    logic        wr_en;
    logic [IDX_W-1:0] wr_idx;
    logic [2:0]  wr_dec;

    // capture and commit
    always_comb begin
        aw_hold_next = aw_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_hold_next  = w_hold_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        wr_en        = 1'b0;
        wr_dec       = dec_addr(aw_addr_reg);
        wr_idx       = wr_dec[1];

        if (i_s_axi_awvalid && o_s_axi_awready) begin
            aw_hold_next = 1'b1;
            aw_addr_next = i_s_axi_awaddr;
        end

        if (i_s_axi_wvalid && o_s_axi_wready) begin
            w_hold_next = 1'b1;
            w_data_next = i_s_axi_wdata;
            w_strb_next = i_s_axi_wstrb;
        end

        // both halves held: commit and answer; status and unmapped refuse
        if (aw_hold_reg && w_hold_reg) begin
            wr_en        = (wr_dec[1:0] != 2'h0);
            bresp_next   = wr_en ? PBC_RESP_OKAY : PBC_RESP_SLVERR;
            bvalid_next  = 1'b1;
            aw_hold_next = 1'b0;
            w_hold_next  = 1'b0;
        end

        if (bvalid_reg && i_s_axi_bready) bvalid_next = 1'b0;
    end

    // bus state flops
    always_ff @(posedge i_clk) begin
        aw_hold_reg     <= i_reset ? 1'b0 : aw_hold_next;
        aw_addr_reg     <= i_reset ? 8'h00 : aw_addr_next;
        w_hold_reg      <= i_reset ? 1'b0 : w_hold_next;
        w_data_reg      <= i_reset ? 32'h0000_0000 : w_data_next;
        w_strb_reg      <= i_reset ? 4'h0 : w_strb_next;

        bvalid_reg      <= i_reset ? 1'b0 : bvalid_next;
        bresp_reg       <= i_reset ? PBC_RESP_OKAY : bresp_next;

        o_s_axi_awready <= i_reset ? 1'b0 :
                           (!aw_hold_next && !bvalid_next);
        o_s_axi_wready  <= i_reset ? 1'b0 :
                           (!w_hold_next && !bvalid_next);
    end

    assign o_s_axi_bvalid = bvalid_reg;
    assign o_s_axi_bresp  = bresp_reg;

    // ****************************************************************
    // register store
    // ****************************************************************
    logic [31:0]           mem_rd;
    logic [N_WORDS*32-1:0] words;
    logic [IDX_W-1:0]      rd_idx;

    pbc_regs #(.N_WORDS(N_WORDS)) u_regs (
        .i_clk     (i_clk),
        .i_reset   (i_reset),
        .i_wr_en   (wr_en),
        .i_wr_idx  (wr_idx),
        .i_wr_data (w_data_reg),
        .i_wr_strb (w_strb_reg),
        .i_rd_idx  (rd_idx),
        .o_rd_data (mem_rd),
        .o_words   (words)
    );

    logic [31:0] pin_cfg;
    logic [31:0] align_cfg;

    assign pin_cfg   = words[31:0];
    assign align_cfg = words[63:32];

    // ****************************************************************
    // read channel: two-cycle answer since store data is registered
    // ****************************************************************
    typedef enum logic [1:0] {
        PBC_RD_IDLE = 2'b00,
        PBC_RD_WAIT = 2'b01,
        PBC_RD_RESP = 2'b10
    } pbc_rd_e;

    pbc_rd_e     rd_st_reg,   rd_st_next;
    logic [2:0]  rd_dec_reg,  rd_dec_next;
    logic [7:0]  ar_addr_reg, ar_addr_next;

    logic [31:0] rdata_next;
    logic [1:0]  rresp_next;

    logic [31:0] status_word;

    // index from the accepting edge on, so store data stand during the wait
    assign rd_idx = rd_dec_next[1];

    // fetch and answer
    always_comb begin
        rd_st_next   = rd_st_reg;
        rd_dec_next  = rd_dec_reg;
        ar_addr_next = ar_addr_reg;
        rdata_next   = o_s_axi_rdata;
        rresp_next   = o_s_axi_rresp;

        case (rd_st_reg)
            PBC_RD_IDLE: begin
                if (i_s_axi_arvalid && o_s_axi_arready) begin
                    ar_addr_next = i_s_axi_araddr;
                    rd_dec_next  = dec_addr(i_s_axi_araddr);
                    rd_st_next   = PBC_RD_WAIT;
                end
            end

            PBC_RD_WAIT: begin
                rd_st_next = PBC_RD_RESP;

                if (rd_dec_reg[2]) begin
                    rdata_next = status_word;
                    rresp_next = PBC_RESP_OKAY;
                end else if (rd_dec_reg[1:0] != 2'h0) begin
                    rdata_next = mem_rd;
                    rresp_next = PBC_RESP_OKAY;
                end else begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = PBC_RESP_SLVERR;
                end
            end

            PBC_RD_RESP: begin
                if (i_s_axi_rready) rd_st_next = PBC_RD_IDLE;
            end

            default: rd_st_next = PBC_RD_IDLE;
        endcase
    end

    // read state flops
    always_ff @(posedge i_clk) begin
        rd_st_reg       <= i_reset ? PBC_RD_IDLE : rd_st_next;
        rd_dec_reg      <= i_reset ? 3'h0 : rd_dec_next;
        ar_addr_reg     <= i_reset ? 8'h00 : ar_addr_next;

        o_s_axi_rdata   <= i_reset ? 32'h0000_0000 : rdata_next;
        o_s_axi_rresp   <= i_reset ? PBC_RESP_OKAY : rresp_next;

        o_s_axi_rvalid  <= i_reset ? 1'b0 : (rd_st_next == PBC_RD_RESP);
        o_s_axi_arready <= i_reset ? 1'b0 : (rd_st_next == PBC_RD_IDLE);
    end

    // ****************************************************************
    // feedback pin
    // ****************************************************************
    logic fb_level;

    pbc_fb_sel u_fb (
        .i_clk           (i_clk),
        .i_reset         (i_reset),
        .i_state         (i_motor_state),
        .i_stop_sel      (pin_cfg[PBC_STOP_SEL_LSB +: PBC_SEL_W]),
        .i_fault_sel     (pin_cfg[PBC_FAULT_SEL_LSB +: PBC_SEL_W]),
        .i_general_level (i_general_feedback_setting),
        .i_run_level     (i_run_feedback_level),
        .o_level         (fb_level)
    );

    // feedback straight from the selector flop
    assign o_speed_feedback_out = fb_level;


    // ****************************************************************
    // alarm and brake control
    // ****************************************************************
    logic                alarm_next;
    logic                lsb_next;
    logic                alb_next;
    logic [ANGLE_W-1:0]  ang_next;

    logic                braking_reg;

    // angle captured on align brake entry, then held
    always_comb begin
        alarm_next = pin_cfg[PBC_ALARM_EN_BIT] & i_alarm_event; // RL5

        lsb_next   = i_brake_req & ~pin_cfg[PBC_BRAKE_STY_BIT]; // RL6
        alb_next   = i_brake_req &  pin_cfg[PBC_BRAKE_STY_BIT]; // RL6

        ang_next   = o_brake_angle;
        if (alb_next && !braking_reg) begin
            ang_next = pin_cfg[PBC_ANG_SRC_BIT] ? align_cfg[ANGLE_W-1:0]    // RL7
                                                : i_last_comm_angle;        // RL7
        end
    end

    // pin output flops
    always_ff @(posedge i_clk) begin
        o_alarm_pin      <= i_reset ? 1'b0 : alarm_next;
        o_low_side_brake <= i_reset ? 1'b0 : lsb_next;
        o_align_brake    <= i_reset ? 1'b0 : alb_next;

        braking_reg      <= i_reset ? 1'b0 : alb_next;
        o_brake_angle    <= i_reset ? '0 : ang_next;
    end

    // live status view
    always_comb begin
        status_word = 32'h0000_0000;

        status_word[PBC_ST_FB_BIT]         = fb_level;
        status_word[PBC_ST_STATE_LSB +: 2] = i_motor_state;
        status_word[PBC_ST_ALARM_BIT]      = o_alarm_pin;
        status_word[PBC_ST_LSBRK_BIT]      = o_low_side_brake;
        status_word[PBC_ST_ALBRK_BIT]      = o_align_brake;
    end

endmodule : pbc_top

// ==== sim/pbc_checker.sv ====
// checker: port-level relations of the pin behaviour config block
`timescale 1ns/1ps
module pbc_checker #(
    parameter int ANGLE_W = 16
) (
    input wire logic               i_clk,
    input wire logic               i_reset,
    input wire logic [7:0]         i_s_axi_awaddr,
    input wire logic               i_s_axi_awvalid,
    input wire logic               o_s_axi_awready,
    input wire logic [31:0]        i_s_axi_wdata,
    input wire logic               i_s_axi_wvalid,
    input wire logic               o_s_axi_wready,
    input wire logic [1:0]         o_s_axi_bresp,
    input wire logic               o_s_axi_bvalid,
    input wire logic               i_s_axi_bready,
    input wire pbc_pkg::pbc_motor_e i_motor_state,
    input wire logic               i_general_feedback_setting,
    input wire logic               i_run_feedback_level,
    input wire logic               i_alarm_event,
    input wire logic               i_brake_req,
    input wire logic [ANGLE_W-1:0] i_last_comm_angle,
    input wire logic               o_speed_feedback_out,
    input wire logic               o_alarm_pin,
    input wire logic               o_low_side_brake,
    input wire logic               o_align_brake,
    input wire logic [ANGLE_W-1:0] o_brake_angle
);
    import pbc_pkg::*;
    logic [7:0]         aw_q;
    logic [31:0]        wd_q;
    logic [31:0]        cfg;
    logic [ANGLE_W-1:0] ang;
    logic [1:0]         quiet;
    logic               idle;
    // checks wait for a quiet write path
    assign idle = quiet == 2'h3 && !i_s_axi_awvalid && !i_s_axi_wvalid && !o_s_axi_bvalid;
    // shadow of pin config and align angle, rebuilt from accepted writes
    always_ff @(posedge i_clk) begin
        if (o_s_axi_awready && i_s_axi_awvalid) aw_q <= i_s_axi_awaddr;
        if (o_s_axi_wready && i_s_axi_wvalid) wd_q <= i_s_axi_wdata;
        if (i_reset || i_s_axi_awvalid || i_s_axi_wvalid || o_s_axi_bvalid) quiet <= 2'h0;
        else if (quiet != 2'h3) quiet <= quiet + 2'h1;
        if (i_reset) begin
            cfg <= '0;
            ang <= '0;
        end else if (o_s_axi_bvalid && i_s_axi_bready && o_s_axi_bresp == PBC_RESP_OKAY) begin
            if (aw_q == PBC_OFS_PIN_CFG) cfg <= wd_q;
            if (aw_q == PBC_OFS_ALIGN_ANG) ang <= wd_q[ANGLE_W-1:0];
        end
    end
    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    a_stop_general: assert property (
        idle && i_motor_state == PBC_STOP && cfg[10:9] == 2'h0
        |=> o_speed_feedback_out == $past(i_general_feedback_setting)) else $error("stop level");
    a_stop_forced: assert property (
        idle && i_motor_state == PBC_STOP && cfg[10:9] != 2'h0
        |=> o_speed_feedback_out == ($past(cfg[10:9]) != 2'h2)) else $error("stop forced");
    a_fault_hold: assert property (
        idle && $past(i_motor_state) == PBC_RUN && i_motor_state == PBC_FAULT && cfg[8:7] == 2'h0
        |=> o_speed_feedback_out == $past(i_run_feedback_level, 2)) else $error("fault hold");
    a_fault_forced: assert property (
        idle && i_motor_state == PBC_FAULT && cfg[8] != cfg[7]
        |=> o_speed_feedback_out == $past(cfg[7])) else $error("fault forced");
    a_fault_general: assert property (
        idle && i_motor_state == PBC_FAULT && cfg[8:7] == 2'h3
        |=> o_speed_feedback_out == $past(i_general_feedback_setting)) else $error("fault gen");
    a_alarm_gate: assert property (
        idle |=> o_alarm_pin == ($past(cfg[6]) && $past(i_alarm_event))) else $error("alarm");
    a_brake_style: assert property (
        idle && i_brake_req |=> o_low_side_brake != $past(cfg[5]) && o_align_brake == $past(cfg[5]))
        else $error("brake style");
    a_align_angle: assert property (
        idle && $rose(i_brake_req) && cfg[5] |-> ##2
        o_brake_angle == (cfg[4] ? ang : $past(i_last_comm_angle, 2))) else $error("angle");
    a_state_react: assert property (
        idle && $changed(i_motor_state) && i_motor_state == PBC_STOP && cfg[10:9] == 2'h2
        |=> !o_speed_feedback_out) else $error("state change late");
endmodule : pbc_checker

bind pbc_top pbc_checker #(.ANGLE_W(ANGLE_W)) i_chk (.*);

// ==== sim/pbc_core_model.sv ====
// partner model: motor core with run feedback level and angle
`timescale 1ns/1ps
module pbc_core_model (
    input  wire logic                i_clk,
    input  wire pbc_pkg::pbc_motor_e i_state,
    output logic                     o_run_level,
    output logic [15:0]              o_angle
);
    import pbc_pkg::*;
    logic [1:0] div_reg;
    initial begin
        div_reg     = 2'h0;
        o_run_level = 1'b0;
        o_angle     = 16'h1234;
    end
    // run: toggles every third cycle; else flips each cycle to expose pass-through
    always @(posedge i_clk) begin
        div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
        if (i_state != PBC_RUN || div_reg == 2'h2) begin
            o_run_level <= ~o_run_level;
        end
        if (i_state == PBC_RUN) begin
            o_angle <= o_angle + 16'h0101;
        end
    end
endmodule : pbc_core_model

// ==== sim/test_pin_behaviour_config.sv ====
// testbench: pin behaviour config block, table cases then edge cases
`timescale 1ns/1ps
module test_pin_behaviour_config;
    import pbc_pkg::*;
    typedef struct {
        logic [31:0] cfg;
        logic [1:0]  st;
        logic [2:0]  inp;
        logic [3:0]  ex;
    } pbc_row_s;
    logic        i_clk = 1'b0;
    logic        i_reset = 1'b1;
    logic [7:0]  i_s_axi_awaddr = 8'h00;
    logic        i_s_axi_awvalid = 1'b0;
    logic [31:0] i_s_axi_wdata = 32'h0;
    logic [3:0]  i_s_axi_wstrb = 4'hf;
    logic        i_s_axi_wvalid = 1'b0;
    logic        i_s_axi_bready = 1'b0;
    logic [7:0]  i_s_axi_araddr = 8'h00;
    logic        i_s_axi_arvalid = 1'b0;
    logic        i_s_axi_rready = 1'b0;
    pbc_motor_e  i_motor_state = PBC_RUN;
    logic        i_general_feedback_setting = 1'b0;
    logic        i_alarm_event = 1'b0;
    logic        i_brake_req = 1'b0;
    logic        i_run_feedback_level;
    logic [15:0] i_last_comm_angle;
    logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic [1:0]  o_s_axi_bresp, o_s_axi_rresp, rsp;
    logic [31:0] o_s_axi_rdata, rd;
    logic        o_speed_feedback_out, o_alarm_pin, o_low_side_brake, o_align_brake;
    logic [15:0] o_brake_angle, exp_ang;
    int          error_cnt = 0;
    int          n_tests = 0;
    // cfg, state, {general, alarm, brake}, {fb, alarm, low brake, align brake}
    pbc_row_s    rows [12] = '{
        '{32'h0, 2'h1, 3'b100, 4'b1000}, '{32'h40, 2'h1, 3'b010, 4'b0100},
        '{32'h200, 2'h1, 3'b000, 4'b1000}, '{32'h400, 2'h1, 3'b100, 4'b0000},
        '{32'h600, 2'h1, 3'b000, 4'b1000}, '{32'h80, 2'h2, 3'b000, 4'b1000},
        '{32'h100, 2'h2, 3'b100, 4'b0000}, '{32'h180, 2'h2, 3'b100, 4'b1000},
        '{32'h180, 2'h2, 3'b010, 4'b0000}, '{32'h200, 2'h1, 3'b001, 4'b1010},
        '{32'h220, 2'h1, 3'b000, 4'b1000}, '{32'h220, 2'h1, 3'b001, 4'b1001}};

    always #4 i_clk = ~i_clk;
    pbc_top #(.ANGLE_W(16)) i_dut (.*);
    pbc_core_model i_core (.i_clk(i_clk), .i_state(i_motor_state),
        .o_run_level(i_run_feedback_level), .o_angle(i_last_comm_angle));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic settle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : settle
    // channels drop at the edge that takes them
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        {i_s_axi_awaddr, i_s_axi_wdata} <= {a, d};
        {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} <= 3'b111;
        do begin
            @(posedge i_clk);
            if (o_s_axi_awready === 1'b1) i_s_axi_awvalid <= 1'b0;
            if (o_s_axi_wready === 1'b1) i_s_axi_wvalid <= 1'b0;
        end while (o_s_axi_bvalid !== 1'b1);
        r = o_s_axi_bresp;
        i_s_axi_bready <= 1'b0;
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_clk);
        i_s_axi_araddr <= a;
        {i_s_axi_arvalid, i_s_axi_rready} <= 2'b11;
        do begin
            @(posedge i_clk);
            if (o_s_axi_arready === 1'b1) i_s_axi_arvalid <= 1'b0;
        end while (o_s_axi_rvalid !== 1'b1);
        {d, r} = {o_s_axi_rdata, o_s_axi_rresp};
        i_s_axi_rready <= 1'b0;
    endtask : axi_rd
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin : main
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        axi_rd(PBC_OFS_PIN_CFG, rd, rsp);
        chk(rd, PBC_PIN_CFG_RST);
        axi_wr(PBC_OFS_STATUS, 32'h7f0, rsp);
        chk(rsp, PBC_RESP_SLVERR);
        axi_rd(8'h0c, rd, rsp);
        chk(rd, 32'h0);
        chk(rsp, PBC_RESP_SLVERR);
        $display("bus map test done");
        foreach (rows[k]) begin
            axi_wr(PBC_OFS_PIN_CFG, rows[k].cfg, rsp);
            chk(rsp, PBC_RESP_OKAY);
            i_motor_state <= pbc_motor_e'(rows[k].st);
            {i_general_feedback_setting, i_alarm_event, i_brake_req} <= rows[k].inp;
            settle(5);
            chk({o_speed_feedback_out, o_alarm_pin, o_low_side_brake, o_align_brake}, rows[k].ex);
        end
        axi_rd(PBC_OFS_PIN_CFG, rd, rsp);
        chk(rd, 32'h220);
        $display("table test done");
        // fault sel zero keeps last run level
        i_brake_req <= 1'b0;
        axi_wr(PBC_OFS_PIN_CFG, 32'h0, rsp);
        for (int k = 0; k < 2; k++) begin
            i_motor_state <= PBC_RUN;
            repeat (4) @(posedge i_clk);
            while (i_run_feedback_level !== k[0]) @(posedge i_clk);
            i_motor_state <= PBC_FAULT;
            settle(5);
            chk(o_speed_feedback_out, k[0]);
        end
        $display("fault hold test done");
        axi_wr(PBC_OFS_PIN_CFG, 32'h480, rsp);
        settle(4);
        chk(o_speed_feedback_out, 1'b1);
        @(posedge i_clk);
        i_motor_state <= PBC_STOP;
        settle(1);
        chk(o_speed_feedback_out, 1'b0);
        i_motor_state <= PBC_FAULT;
        settle(1);
        chk(o_speed_feedback_out, 1'b1);
        $display("state change test done");
        // configured angle, then captured one held while angle moves
        axi_wr(PBC_OFS_ALIGN_ANG, 32'h5a3c, rsp);
        chk(rsp, PBC_RESP_OKAY);
        axi_rd(PBC_OFS_ALIGN_ANG, rd, rsp);
        chk(rd, 32'h5a3c);
        axi_wr(PBC_OFS_PIN_CFG, 32'h230, rsp);
        i_motor_state <= PBC_STOP;
        for (int k = 0; k < 2; k++) begin
            repeat (5) @(posedge i_clk);
            exp_ang = k ? i_last_comm_angle : 16'h5a3c;
            i_brake_req <= 1'b1;
            settle(4);
            chk(o_brake_angle, exp_ang);
            i_motor_state <= PBC_RUN;
            settle(4);
            chk(o_brake_angle, exp_ang);
            chk({o_low_side_brake, o_align_brake}, 2'b01);
            i_brake_req <= 1'b0;
            i_motor_state <= PBC_STOP;
            axi_wr(PBC_OFS_PIN_CFG, 32'h220, rsp);
        end
        $display("align angle test done");
        test_done();
    end
    // only cuts a hung handshake short
    initial begin : watchdog
        repeat (5000) @(posedge i_clk);
        error_cnt++;
        $display("BAD t=%0t watchdog expired", $time);
        test_done();
    end
endmodule : test_pin_behaviour_config
